// ===== rtl/hlr_defs.svh
// Offsets, field positions, reset values and timing counts of the
// link reset and power sequencer. Definitions only.
`ifndef HLR_DEFS_SVH
`define HLR_DEFS_SVH

// Register byte offsets
`define HLR_OFS_CTRL_CFG    12'h000
`define HLR_OFS_SYS_STAT    12'h004
`define HLR_OFS_LINK_CFG    12'h010
`define HLR_OFS_LINK_STAT   12'h014
`define HLR_OFS_PHY_STATE   12'h050

// controller_config_reg fields
`define HLR_CC_SOFT_RST     0
`define HLR_CC_SLEEP        1
`define HLR_CC_OPEN_LOOP    28
`define HLR_CC_RETRY_DIS    29
`define HLR_CC_SCRAM_DIS    30
`define HLR_CC_SIM_FAST     31
`define HLR_CC_RESET        32'h0000_0001
`define HLR_CC_WMASK        32'hF000_0003

// system_status_reg fields
`define HLR_SS_GT_DONE      0
`define HLR_SS_TX_DONE      1
`define HLR_SS_RX_DONE      2
`define HLR_SS_FULL_WIDTH   12

// link_config_reg fields
`define HLR_LC_WARM         0
`define HLR_LC_INIT         1
`define HLR_LC_RETRAIN      8
`define HLR_LC_RESET        32'h0000_0008
`define HLR_LC_WMASK        32'h0000_017F

// link_status_reg fields
`define HLR_LS_INIT_DONE    17
`define HLR_LS_DESKEW       18
`define HLR_LS_PHY_RST_DONE 19

// Link geometry
`define HLR_LANES_FULL      16
`define HLR_LANES_HALF      8
`define HLR_FULL_WIDTH      1'b0
`define HLR_LANE_RATE_MBPS  10000
`define HLR_SYS_BUS_BITS    256
`define HLR_GT_USER_MHZ     312
`define HLR_SPEED_CODE      4'h0
`define HLR_FLIT_N          4'h2

// Timing
`define HLR_CLK_MHZ         100
`define HLR_HOLD_NS         1000
`define HLR_HOLD_SIM_NS     100
`define HLR_WAKE_NS         200
`define HLR_HOLD_CYC  ((`HLR_HOLD_NS * `HLR_CLK_MHZ + 999) / 1000)
`define HLR_HSIM_CYC  ((`HLR_HOLD_SIM_NS * `HLR_CLK_MHZ + 999) / 1000)
`define HLR_WAKE_CYC  ((`HLR_WAKE_NS * `HLR_CLK_MHZ + 999) / 1000)

`endif

// ===== rtl/hlr_pkg.sv
// Types shared by the sequencer files.
// Assumes the constants header is included by users that need numbers.
package hlr_pkg;

   typedef enum logic [8:0] {
      ST_HOLD  = 9'b0_0000_0001,
      ST_TX_UP = 9'b0_0000_0010,
      ST_DEV   = 9'b0_0000_0100,
      ST_WAIT  = 9'b0_0000_1000,
      ST_RX_UP = 9'b0_0001_0000,
      ST_TRAIN = 9'b0_0010_0000,
      ST_UP    = 9'b0_0100_0000,
      ST_SLEEP = 9'b0_1000_0000,
      ST_WAKE  = 9'b1_0000_0000
   } hlr_state_t;

   typedef enum logic [2:0] {
      PHY_IDLE  = 3'h0,
      PHY_TS1   = 3'h2,
      PHY_UP    = 3'h5
   } hlr_phy_t;

endpackage

// ===== rtl/hlr_sync2.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a slow level; multi-bit words are not coherent.
`timescale 1ns/1ps
module hlr_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,                  // Destination clock
   input wire logic rst_n,                // Async reset, active low
   input wire logic [WIDTH-1:0] d,        // Asynchronous levels
   output logic [WIDTH-1:0] q             // Synchronised levels
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// ===== rtl/hlr_timer.sv
// Down-counting interval timer: load starts it, done is high at zero.
// Assumes load comes from the same clock; while held high it keeps reloading.
`timescale 1ns/1ps
module hlr_timer #(
   parameter int WIDTH = 12
) (
   input wire logic clk,                  // Clock
   input wire logic rst_n,                // Async reset, active low
   input wire logic load,                 // Restart with count
   input wire logic [WIDTH-1:0] count,    // Cycles to run
   output logic done                      // Interval elapsed
);
   logic [WIDTH-1:0] cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= count;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign done = (cnt_r == '0) && !load;
endmodule

// ===== rtl/hlr_top.sv
// Reset, bring-up and power-state sequencer of a serial memory-link
// host controller, with an APB register slave on pclk.
// Assumes transceiver, PHY and device pins are asynchronous levels.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "hlr_defs.svh"
module hlr_top
   import hlr_pkg::*;
(
   input wire logic pclk,                 // Register and sequencer clock
   input wire logic presetn,              // Hard reset, active low
   input wire logic psel,                 // APB select
   input wire logic penable,              // APB access phase
   input wire logic pwrite,               // APB write
   input wire logic [11:0] paddr,         // APB byte address
   input wire logic [31:0] pwdata,        // APB write data
   output logic [31:0] prdata,            // APB read data
   output logic pready,                   // APB ready
   output logic pslverr,                  // APB error, unmapped address
   input wire logic gt_tx_done,           // Transceiver TX reset done
   input wire logic gt_rx_done,           // Transceiver RX reset done
   input wire logic phy_trained,          // PHY training complete
   input wire logic phy_deskewed,         // PHY deskew complete
   input wire logic rx_power_state,       // Device power state in
   output logic gt_tx_rst,                // Transceiver TX reset
   output logic gt_rx_rst,                // Transceiver RX reset
   output logic dev_rst_n,                // Device reset, active low
   output logic phy_train_en,             // Start PHY training
   output logic upper_rst,                // Link/transaction/user reset
   output logic datapath_rst,             // Controller datapath reset
   output logic warm_rst,                 // Link machine and token reset
   output logic tx_power_state,           // Power state out to device
   output logic link_up,                  // Link established
   output logic gearbox_en,               // Width adapter in use
   output logic align_clk_en,             // Alignment clock enable
   output logic open_loop,                // Ignore TX token limit
   output logic scram_dis                 // Scrambler disabled
);

   localparam int HOLD_CYC = `HLR_HOLD_CYC;
   localparam int HSIM_CYC = `HLR_HSIM_CYC;
   localparam int WAKE_CYC = `HLR_WAKE_CYC;
   localparam int LANES = `HLR_FULL_WIDTH ? `HLR_LANES_FULL :
                          `HLR_LANES_HALF;
   // System clock in MHz from the link geometry
   localparam int SYS_MHZ = LANES * `HLR_LANE_RATE_MBPS /
                            `HLR_SYS_BUS_BITS;
   localparam logic NEED_GBX = (SYS_MHZ != `HLR_GT_USER_MHZ);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [4:0] pin_s;
   logic tx_done_s, rx_done_s, trained_s, deskew_s, rxps_s;

   hlr_sync2 #(.WIDTH(5)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({gt_tx_done, gt_rx_done, phy_trained, phy_deskewed,
          rx_power_state}),
      .q(pin_s)
   );
   assign {tx_done_s, rx_done_s, trained_s, deskew_s, rxps_s} = pin_s;

   ////////////////////////////////////////////////////////////////////
   // Registers

   logic [31:0] ctrl_cfg_r;
   logic [31:0] link_cfg_r;
   logic wr_en, rd_sel_ok;
   logic [31:0] rd_val;
   hlr_state_t state_r, state_nxt;
   hlr_phy_t phy_st;

   assign wr_en = psel && penable && pready && pwrite;

   // Only presetn resets these, so soft reset keeps them
   // Live from the first edge after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_cfg_r <= `HLR_CC_RESET;
         link_cfg_r <= `HLR_LC_RESET;
      end else if (wr_en) begin
         if (paddr == `HLR_OFS_CTRL_CFG) begin
            ctrl_cfg_r <= pwdata & `HLR_CC_WMASK;
         end
         if (paddr == `HLR_OFS_LINK_CFG) begin
            link_cfg_r <= pwdata & `HLR_LC_WMASK;
         end
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_sel_ok = 1'b1;
      unique case (paddr)
         `HLR_OFS_CTRL_CFG: rd_val = ctrl_cfg_r;
         `HLR_OFS_SYS_STAT: begin
            // Transmit done readable for polling
            rd_val[`HLR_SS_TX_DONE] = tx_done_s;
            rd_val[`HLR_SS_RX_DONE] = rx_done_s;
            rd_val[`HLR_SS_GT_DONE] = tx_done_s && rx_done_s;
            rd_val[7:4] = `HLR_SPEED_CODE;
            rd_val[11:8] = `HLR_FLIT_N;
            rd_val[`HLR_SS_FULL_WIDTH] = `HLR_FULL_WIDTH;
         end
         `HLR_OFS_LINK_CFG: rd_val = link_cfg_r;
         `HLR_OFS_LINK_STAT: begin
            rd_val[`HLR_LS_INIT_DONE] = link_up;
            rd_val[`HLR_LS_DESKEW] = deskew_s;
            rd_val[`HLR_LS_PHY_RST_DONE] = rx_done_s;
         end
         `HLR_OFS_PHY_STATE: rd_val[2:0] = phy_st;
         default: rd_sel_ok = 1'b0;
      endcase
   end

   // No wait state: ready follows the setup cycle. The register port
   // shares pclk with the sequencer, so no crossing is needed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable && !pready;
         prdata <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
         pslverr <= psel && !penable && !rd_sel_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Reset and power sequencer

   logic soft_rst, sleep_req, init_en, warm_req;
   logic tmr_load, tmr_done;
   logic [11:0] tmr_cnt;
   logic soft_d_r;

   assign soft_rst = ctrl_cfg_r[`HLR_CC_SOFT_RST];
   assign sleep_req = ctrl_cfg_r[`HLR_CC_SLEEP];
   assign init_en = link_cfg_r[`HLR_LC_INIT];
   assign warm_req = link_cfg_r[`HLR_LC_WARM] ||
                     link_cfg_r[`HLR_LC_RETRAIN];

   // Shorter hold when the simulation speed-up bit is set
   always_comb begin
      if (state_nxt == ST_WAKE) begin
         tmr_cnt = 12'(WAKE_CYC);
      end else if (ctrl_cfg_r[`HLR_CC_SIM_FAST]) begin
         tmr_cnt = 12'(HSIM_CYC);
      end else begin
         tmr_cnt = 12'(HOLD_CYC);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_d_r <= 1'b1;
      end else begin
         soft_d_r <= soft_rst;
      end
   end

   // Reload while soft reset is held and one cycle after its release, so
   // the hold starts when software lets go and a speed-up bit written in
   // that same access already counts
   assign tmr_load = soft_d_r ||
                     ((state_nxt != state_r) &&
                      (state_nxt == ST_HOLD || state_nxt == ST_WAKE));

   hlr_timer #(.WIDTH(12)) u_tmr (
      .clk(pclk),
      .rst_n(presetn),
      .load(tmr_load),
      .count(tmr_cnt),
      .done(tmr_done)
   );

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_HOLD:  if (tmr_done && !soft_rst) state_nxt = ST_TX_UP;
         ST_TX_UP: if (tx_done_s) state_nxt = ST_DEV;
         ST_DEV:   state_nxt = ST_WAIT;
         ST_WAIT:  if (init_en) state_nxt = ST_RX_UP;
         ST_RX_UP: if (rx_done_s) state_nxt = ST_TRAIN;
         ST_TRAIN: if (trained_s && init_en && !warm_req) begin
            state_nxt = ST_UP;
         end
         ST_UP: begin
            if (!rxps_s) begin
               state_nxt = ST_SLEEP;
            end else if (warm_req) begin
               state_nxt = ST_TRAIN;
            end
         end
         ST_SLEEP: if (!sleep_req) state_nxt = ST_WAKE;
         ST_WAKE:  if (tmr_done) state_nxt = ST_RX_UP;
         default:  state_nxt = ST_HOLD;
      endcase
      // Soft reset restarts the whole bring-up
      if (soft_rst) begin
         state_nxt = ST_HOLD;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_HOLD;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign phy_st = (state_r == ST_UP) ? PHY_UP :
                   (state_r == ST_TRAIN && init_en) ? PHY_TS1 : PHY_IDLE;

   ////////////////////////////////////////////////////////////////////
   // Registered outputs

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gt_tx_rst <= 1'b1;
         gt_rx_rst <= 1'b1;
         dev_rst_n <= 1'b0;
      end else begin
         gt_tx_rst <= (state_nxt == ST_HOLD);
         gt_rx_rst <= !(state_nxt inside {ST_RX_UP, ST_TRAIN,
                                          ST_UP, ST_SLEEP});
         dev_rst_n <= !(state_nxt inside {ST_HOLD, ST_TX_UP});
      end
   end

   // Upper layers stay in reset until link up, also after wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phy_train_en <= 1'b0;
         upper_rst <= 1'b1;
         link_up <= 1'b0;
         warm_rst <= 1'b0;
         datapath_rst <= 1'b1;
      end else begin
         phy_train_en <= (state_nxt == ST_TRAIN) && init_en;
         upper_rst <= (state_nxt != ST_UP);
         link_up <= (state_nxt == ST_UP);
         warm_rst <= (state_nxt == ST_TRAIN) && warm_req;
         datapath_rst <= soft_rst;
      end
   end

   // Power-state pin: low on request in ST_UP or ST_SLEEP, high again once sleep is cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_power_state <= 1'b1;
      end else if (state_nxt == ST_WAKE) begin
         tx_power_state <= 1'b1;
      end else begin
         tx_power_state <= !(sleep_req && state_nxt inside {ST_UP,
                                                            ST_SLEEP});
      end
   end

   // Static clocking plan and configuration outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gearbox_en <= 1'b0;
         align_clk_en <= 1'b0;
         open_loop <= 1'b0;
         scram_dis <= 1'b0;
      end else begin
         gearbox_en <= NEED_GBX;
         align_clk_en <= NEED_GBX;
         open_loop <= ctrl_cfg_r[`HLR_CC_OPEN_LOOP];
         scram_dis <= ctrl_cfg_r[`HLR_CC_SCRAM_DIS];
      end
   end

endmodule

// ===== bench/hlr_dev_model.sv
// Far-side model: transceiver reset-done flags, PHY training, device power.
// Assumes the sequencer outputs are clean registered levels on clk.
`timescale 1ns/1ps
module hlr_dev_model #(
   parameter int LAT = 6
) (
   input wire logic clk,            // Clock
   input wire logic gt_tx_rst,      // TX reset from sequencer
   input wire logic gt_rx_rst,      // RX reset from sequencer
   input wire logic phy_train_en,   // Training enable
   input wire logic dev_rst_n,      // Device reset, active low
   input wire logic tx_power_state, // Power state request
   output logic gt_tx_done,         // TX reset done
   output logic gt_rx_done,         // RX reset done
   output logic phy_trained,        // Training complete
   output logic phy_deskewed,       // Deskew complete
   output logic rx_power_state      // Device power state answer
);
   logic [7:0] tx_c = 8'h00;
   logic [7:0] rx_c = 8'h00;
   logic [7:0] tr_c = 8'h00;
   // Starts high so the power answer is defined before reset ends
   logic [7:0] ps_sh = 8'hFF;
   ////////////////////////////////////////
   always_ff @(posedge clk) begin
      tx_c <= gt_tx_rst ? 8'h00 : tx_c + {7'h0, tx_c != 8'(LAT)};
      rx_c <= gt_rx_rst ? 8'h00 : rx_c + {7'h0, rx_c != 8'(LAT)};
   end
   // Training result holds until the RX path or the device is reset,
   // so deskew stays reported while the link is up
   always_ff @(posedge clk) begin
      if (gt_rx_rst || !dev_rst_n) begin
         tr_c <= 8'h00;
      end else if (phy_train_en) begin
         tr_c <= tr_c + {7'h0, tr_c != 8'(LAT)};
      end
   end
   always_ff @(posedge clk) begin
      ps_sh <= {ps_sh[6:0], tx_power_state};
   end
   assign gt_tx_done = (tx_c == 8'(LAT));
   assign gt_rx_done = (rx_c == 8'(LAT));
   assign phy_trained = (tr_c == 8'(LAT));
   assign phy_deskewed = phy_trained;
   assign rx_power_state = ps_sh[7];
endmodule

// ===== bench/hlr_top_monitor.sv
// Port assertions for hlr_top, attached by the bind at the foot.
// Assumes one clock pclk and asynchronous active-low presetn.
`timescale 1ns/1ps
module hlr_top_monitor (
   input wire logic pclk,           // Clock
   input wire logic presetn,        // Reset, active low
   input wire logic psel,           // APB select
   input wire logic penable,        // APB enable
   input wire logic pready,         // APB ready
   input wire logic pslverr,        // APB error
   input wire logic gt_tx_rst,      // TX reset
   input wire logic gt_rx_rst,      // RX reset
   input wire logic dev_rst_n,      // Device reset, active low
   input wire logic phy_train_en,   // Training enable
   input wire logic upper_rst,      // Upper layer reset
   input wire logic warm_rst,       // Warm reset level
   input wire logic rx_power_state, // Device power state
   input wire logic tx_power_state, // Power request
   input wire logic link_up,        // Link up pin
   input wire logic gearbox_en,     // Width adapter
   input wire logic align_clk_en    // Alignment clock
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   a_pready_setup: assert property (
      psel && !penable |=> pready) else $error("no ready after setup");
   a_pready_pulse: assert property (
      pready |=> !pready) else $error("ready longer than a cycle");
   a_slverr_ready: assert property (
      pslverr |-> pready) else $error("error without ready");
   a_tx_before_dev: assert property (
      $rose(dev_rst_n) |-> !gt_tx_rst) else $error("device out before tx");
   a_rx_after_dev: assert property (
      $fell(gt_rx_rst) |-> dev_rst_n) else $error("rx up with device held");
   a_train_after_rx: assert property (
      $rose(phy_train_en) |-> !gt_rx_rst && !gt_tx_rst)
      else $error("training before rx ready");
   a_link_layers: assert property (
      link_up |-> !upper_rst && !gt_rx_rst && dev_rst_n)
      else $error("link up with layers held");
   a_sleep_link: assert property (
      (!tx_power_state && !rx_power_state) [*6] |-> !link_up)
      else $error("link up during sleep");
   a_sleep_from_up: assert property (
      $fell(tx_power_state) |-> link_up) else $error("sleep outside link up");
   a_wake_rx_reset: assert property (
      $rose(tx_power_state) |=> gt_rx_rst [*8])
      else $error("rx path not reset at wake");
   a_align_gear: assert property (
      align_clk_en |-> gearbox_en) else $error("align clock without adapter");
   c_link: cover property ($rose(link_up));
   c_sleep: cover property ($fell(tx_power_state));
   c_warm: cover property ($rose(warm_rst));
endmodule
bind hlr_top hlr_top_monitor mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .gt_tx_rst(gt_tx_rst),
   .gt_rx_rst(gt_rx_rst), .dev_rst_n(dev_rst_n),
   .phy_train_en(phy_train_en), .upper_rst(upper_rst),
   .warm_rst(warm_rst), .rx_power_state(rx_power_state),
   .tx_power_state(tx_power_state), .link_up(link_up),
   .gearbox_en(gearbox_en), .align_clk_en(align_clk_en));

// ===== bench/hlr_top_test.sv
// Self-checking bench for hlr_top with the device model on its far side.
// Assumes hlr_dev_model and the bound monitor are compiled first.
`timescale 1ns/1ps
`include "hlr_defs.svh"
module hlr_top_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, gt_tx_done, gt_rx_done, phy_trained;
   logic phy_deskewed, rx_power_state, gt_tx_rst, gt_rx_rst, dev_rst_n;
   logic phy_train_en, upper_rst, datapath_rst, warm_rst, tx_power_state;
   logic link_up, gearbox_en, align_clk_en, open_loop, scram_dis;
   int mismatches = 0;
   int n_checks = 0;
   always #5 pclk = ~pclk;
   hlr_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gt_tx_done(gt_tx_done), .gt_rx_done(gt_rx_done),
      .phy_trained(phy_trained), .phy_deskewed(phy_deskewed),
      .rx_power_state(rx_power_state), .gt_tx_rst(gt_tx_rst),
      .gt_rx_rst(gt_rx_rst), .dev_rst_n(dev_rst_n),
      .phy_train_en(phy_train_en), .upper_rst(upper_rst),
      .datapath_rst(datapath_rst), .warm_rst(warm_rst),
      .tx_power_state(tx_power_state), .link_up(link_up),
      .gearbox_en(gearbox_en), .align_clk_en(align_clk_en),
      .open_loop(open_loop), .scram_dis(scram_dis));
   hlr_dev_model dev (.clk(pclk), .gt_tx_rst(gt_tx_rst),
      .gt_rx_rst(gt_rx_rst), .phy_train_en(phy_train_en),
      .dev_rst_n(dev_rst_n), .tx_power_state(tx_power_state),
      .gt_tx_done(gt_tx_done), .gt_rx_done(gt_rx_done),
      .phy_trained(phy_trained), .phy_deskewed(phy_deskewed),
      .rx_power_state(rx_power_state));
   ////////////////////////////////////////
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Returns {pslverr, prdata}; the extra edge leaves psel low for one idle cycle
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, output logic [32:0] q);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) mismatches++;
      q = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [32:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      logic [32:0] q;
      apb(1'b0, a, 32'h0000_0000, q);
      check(q, exp);
   endtask
   task automatic poll(input logic [11:0] a, input int b);
      logic [32:0] q;
      int n;
      n = 0;
      q = '0;
      while (q[b] !== 1'b1 && n < 400) begin
         apb(1'b0, a, 32'h0000_0000, q);
         n++;
      end
      check(q[b], 1'b1);
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return link_up;
         1: return tx_power_state;
         default: return warm_rst;
      endcase
   endfunction
   task automatic wait_sig(input int k, input logic v);
      int n;
      n = 0;
      while (sig(k) !== v && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      check(sig(k), v);
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1; // Clock already runs
   endtask
   ////////////////////////////////////////
   task automatic t_defaults();
      check({gearbox_en, align_clk_en, open_loop, scram_dis}, 0);
      check({gt_tx_rst, dev_rst_n, upper_rst, datapath_rst}, 4'hB);
      rd(`HLR_OFS_CTRL_CFG, {1'b0, `HLR_CC_RESET});
      rd(`HLR_OFS_SYS_STAT, {21'h0, `HLR_FLIT_N, 8'h00});
      rd(`HLR_OFS_LINK_CFG, {1'b0, `HLR_LC_RESET});
      wr(`HLR_OFS_LINK_STAT, 32'hFFFF_FFFF);
      rd(`HLR_OFS_LINK_STAT, 33'h0_0000_0000);
      rd(12'h100, 33'h1_0000_0000);
      $display("test defaults done");
   endtask
   task automatic t_bringup();
      wr(`HLR_OFS_CTRL_CFG, 32'hD000_0000);
      @(posedge pclk);
      check(gt_tx_rst, 1'b1);
      poll(`HLR_OFS_SYS_STAT, 1);
      check({gt_tx_rst, dev_rst_n}, 2'b01);
      repeat (30) @(posedge pclk);
      check({gt_rx_rst, phy_train_en, open_loop, scram_dis}, 4'hB);
      wr(`HLR_OFS_LINK_CFG, 32'h0000_000A);
      poll(`HLR_OFS_LINK_STAT, 17);
      check({link_up, upper_rst, gt_rx_rst}, 3'b100);
      rd(`HLR_OFS_LINK_STAT, 33'h0_000E_0000);
      rd(`HLR_OFS_PHY_STATE, {30'h0, hlr_pkg::PHY_UP});
      rd(`HLR_OFS_SYS_STAT, {21'h0, `HLR_FLIT_N, 8'h07});
      $display("test bringup done");
   endtask
   task automatic t_warm();
      wr(`HLR_OFS_LINK_CFG, 32'h0000_000B);
      wait_sig(2, 1'b1);
      wait_sig(0, 1'b0);
      wr(`HLR_OFS_LINK_CFG, 32'h0000_000A);
      wait_sig(0, 1'b1);
      check(warm_rst, 1'b0);
      wr(`HLR_OFS_LINK_CFG, 32'h0000_010A);
      wait_sig(2, 1'b1);
      wr(`HLR_OFS_LINK_CFG, 32'h0000_000A);
      wait_sig(0, 1'b1);
      $display("test warm done");
   endtask
   task automatic t_sleep();
      wr(`HLR_OFS_CTRL_CFG, 32'hD000_0002);
      wait_sig(1, 1'b0);
      wait_sig(0, 1'b0);
      wr(`HLR_OFS_LINK_CFG, 32'h0000_0008);
      wr(`HLR_OFS_CTRL_CFG, 32'hD000_0000);
      wait_sig(1, 1'b1);
      check(gt_rx_rst, 1'b1);
      wr(`HLR_OFS_LINK_CFG, 32'h0000_000A);
      poll(`HLR_OFS_LINK_STAT, 17);
      $display("test sleep done");
   endtask
   task automatic t_soft();
      wr(`HLR_OFS_CTRL_CFG, 32'hD000_0001);
      wait_sig(0, 1'b0);
      rd(`HLR_OFS_CTRL_CFG, 33'h0_D000_0001);
      rd(`HLR_OFS_LINK_CFG, 33'h0_0000_000A);
      check({gt_tx_rst, dev_rst_n, datapath_rst, scram_dis}, 4'hB);
      do_reset();
      rd(`HLR_OFS_CTRL_CFG, {1'b0, `HLR_CC_RESET});
      rd(`HLR_OFS_LINK_CFG, {1'b0, `HLR_LC_RESET});
      $display("test resets done");
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      do_reset();
      t_defaults();
      t_bringup();
      t_warm();
      t_sleep();
      t_soft();
      final_report();
   end
   // Whole run needs a few hundred cycles
   initial begin
      repeat (40000) @(posedge pclk);
      mismatches++;
      final_report();
   end
endmodule
